/* File: rtl/sleep_clock_gating.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - each writable bit outside the rate field 9:8 is a unit clock enable: 1 runs the unit, 0 stops it.
// - an access to a unit whose clock is off ends in a bus fault.
// - after reset all enables are 0 except those given another reset value.
// - this register drives unit clocks only while the system sleeps.
// - sleep values apply only with automatic gating selected, else run ones.
// - bit 16 gates converter 0, resets to 0, read and write.
// - bits 9:8 pick the converter rate, 3/2/1/0 for 1M/500K/250K/125K.
// - bit 6 gates the hibernation unit and resets to 1.
// - bit 3 gates the watchdog, resets to 0, read and write.
// - reserved bits read 0 and software preserves them on updates.
// - the register answers at offset 0x110 of the control window.

module sleep_clock_gating
  import sleep_gate_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // power mode and neighbouring gating registers
  input  wire logic              sleep_mode,
  input  wire logic              deep_sleep_mode,
  input  wire logic              auto_clock_gate_select,
  input  wire gate_cfg_t         run_clock_gate_0,
  input  wire gate_cfg_t         deep_sleep_clock_gate_0,
  // resulting unit clocks and converter rate
  output unit_gate_t             unit_clk_en,
  output sample_rate_t           converter_sample_rate,
  // unit access attempts and their outcome
  input  wire unit_gate_t        unit_access,
  output unit_gate_t             unit_fault,
  output unit_gate_t             unit_grant
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  bus_state_t        state;
  bus_state_t        next_state;
  gate_cfg_t         sleep_clock_gate_0;
  gate_cfg_t         next_cfg;
  logic              addr_hit;
  logic              access_phase;
  logic              wr_done;
  logic [DATA_W-1:0] reg_word;
  logic [N_UNITS-1:0] access_vec;
  logic [N_UNITS-1:0] en_vec;
  logic [N_UNITS-1:0] fault_vec;
  logic [N_UNITS-1:0] grant_vec;
  logic              use_sleep;
  logic              use_deep;
  logic              seen_clk;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------

  // full-width compare, so aliases of the register do not exist
  assign addr_hit     = (paddr == SLEEP_CLOCK_GATE_0_OFS);
  assign access_phase = psel & penable;
  // a write lands only at the edge where pready is seen high
  assign wr_done      = access_phase & pready & pwrite & addr_hit;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------

  // one wait state: pready rises in the second access cycle
  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (access_phase) begin
          next_state = BUS_RESP;
        end
      end
      BUS_RESP: begin
        next_state = BUS_IDLE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pready from a flop, so the answer never races the address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_state == BUS_RESP);
    end
  end

  // ---------------------------------------------------------------
  // gating register
  // ---------------------------------------------------------------

  // only mapped field bits are taken; reserved bits never store
  always_comb begin
    next_cfg = sleep_clock_gate_0;
    if (wr_done) begin
      next_cfg = word_to_cfg(pwdata & SLEEP_CLOCK_GATE_0_WMASK);
    end
  end

  // hibernation enable comes out of reset set, the rest clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_clock_gate_0 <= CFG_RST;
    end else begin
      sleep_clock_gate_0 <= next_cfg;
    end
  end

  // reserved positions are rebuilt as zero on every read
  assign reg_word = cfg_to_word(sleep_clock_gate_0);

  // ---------------------------------------------------------------
  // read data and error
  // ---------------------------------------------------------------

  // data and error are loaded together with pready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (next_state == BUS_RESP) begin
      prdata  <= (addr_hit && !pwrite) ? reg_word : '0;
      pslverr <= ~addr_hit;
    end else begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mode selection
  // ---------------------------------------------------------------

  // without automatic gating the run register governs every mode
  assign use_deep  = auto_clock_gate_select & deep_sleep_mode;
  assign use_sleep = auto_clock_gate_select & sleep_mode
                     & ~deep_sleep_mode;

  // registered so unit clock enables never glitch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_clk_en           <= CFG_RST.gate;
      converter_sample_rate <= CFG_RST.rate;
    end else if (use_deep) begin
      unit_clk_en           <= deep_sleep_clock_gate_0.gate;
      converter_sample_rate <= deep_sleep_clock_gate_0.rate;
    end else if (use_sleep) begin
      unit_clk_en           <= sleep_clock_gate_0.gate;
      converter_sample_rate <= sleep_clock_gate_0.rate;
    end else begin
      unit_clk_en           <= run_clock_gate_0.gate;
      converter_sample_rate <= run_clock_gate_0.rate;
    end
  end

  // ---------------------------------------------------------------
  // unit access guards
  // ---------------------------------------------------------------

  // the guard looks at the enable actually in force, not the register
  assign access_vec = unit_access;
  assign en_vec     = unit_clk_en;

  for (genvar i = 0; i < N_UNITS; i++) begin : g_guard
    unit_access_guard u_guard (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .access   (access_vec[i]),
      .clk_en   (en_vec[i]),
      .fault    (fault_vec[i]),
      .grant    (grant_vec[i])
    );
  end

  assign unit_fault = fault_vec;
  assign unit_grant = grant_vec;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // marks the first clock after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_reset_value: assert property (
    !seen_clk |-> reg_word == SLEEP_CLOCK_GATE_0_RST
                  && unit_clk_en.hibernation && !unit_clk_en.adc)
    else $error("gating register left reset with wrong value");

  // looks at the bus, where a stray reserved bit would be seen
  a_reserved_zero: assert property (
    (prdata & ~SLEEP_CLOCK_GATE_0_WMASK) == '0)
    else $error("reserved bit of gating register is set");

  // a write keeps the mapped bits and drops every other one
  a_reserved_write: assert property (
    wr_done |=> (reg_word & ~SLEEP_CLOCK_GATE_0_WMASK) == '0
                && reg_word == ($past(pwdata)
                                & SLEEP_CLOCK_GATE_0_WMASK))
    else $error("write did not store exactly the mapped bits");

  a_adc_write: assert property (
    wr_done |=> sleep_clock_gate_0.gate.adc == $past(pwdata[ADC_BIT]))
    else $error("converter enable did not follow write");

  a_unit_bits_write: assert property (
    wr_done |=> sleep_clock_gate_0.gate.hibernation
                == $past(pwdata[HIBERNATION_BIT])
                && sleep_clock_gate_0.gate.watchdog
                   == $past(pwdata[WATCHDOG_BIT]))
    else $error("hibernation or watchdog enable missed write");

  a_rate_write: assert property (
    wr_done |=> sleep_clock_gate_0.rate
                == $past(pwdata[RATE_MSB:RATE_LSB]))
    else $error("sample rate field did not follow write");

  // an errored or unmapped write must leave the register alone
  a_no_stray_write: assert property (
    !wr_done |=> $stable(sleep_clock_gate_0))
    else $error("gating register changed without a write");

  // ---------------------------------------------------------------
  // bus answer checks
  // ---------------------------------------------------------------

  a_read_decode: assert property (
    access_phase && !pready && !pwrite && addr_hit
    |=> pready && !pslverr && prdata == reg_word)
    else $error("read of gating register returned wrong data");

  a_unmapped_err: assert property (
    access_phase && !pready && !addr_hit
    |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not answered with error");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held beyond one cycle");

  // nothing may answer before the access phase has begun
  a_setup_quiet: assert property (
    psel && !penable && !pready |=> !pready)
    else $error("pready rose during a setup cycle");

  a_write_ack: assert property (
    access_phase && !pready && pwrite && addr_hit
    |=> pready && !pslverr && prdata == '0)
    else $error("write to gating register not acknowledged");

  // read data and error are zero outside the answer cycle
  a_idle_quiet: assert property (
    !pready |-> prdata == '0 && !pslverr)
    else $error("read data or error driven outside answer cycle");

  // ---------------------------------------------------------------
  // power mode selection checks
  // ---------------------------------------------------------------

  // the release edge still loads reset values, so it is skipped
  a_sleep_select: assert property (
    seen_clk && auto_clock_gate_select && sleep_mode && !deep_sleep_mode
    |=> unit_clk_en == $past(sleep_clock_gate_0.gate)
        && converter_sample_rate == $past(sleep_clock_gate_0.rate))
    else $error("sleep enables not applied in sleep");

  a_run_select: assert property (
    seen_clk && !auto_clock_gate_select
    |=> unit_clk_en == $past(run_clock_gate_0.gate)
        && converter_sample_rate == $past(run_clock_gate_0.rate))
    else $error("run enables not applied without automatic gating");

  a_deep_select: assert property (
    seen_clk && auto_clock_gate_select && deep_sleep_mode
    |=> unit_clk_en == $past(deep_sleep_clock_gate_0.gate)
        && converter_sample_rate == $past(deep_sleep_clock_gate_0.rate))
    else $error("deep sleep enables not applied");

  // ---------------------------------------------------------------
  // unit access checks
  // ---------------------------------------------------------------

  a_fault_path: assert property (
    unit_access.watchdog && !unit_clk_en.watchdog |=> unit_fault.watchdog)
    else $error("watchdog access while gated gave no fault");

  a_adc_fault: assert property (
    unit_access.adc && !unit_clk_en.adc |=> unit_fault.adc)
    else $error("converter access while gated gave no fault");

  a_hibernation_fault: assert property (
    unit_access.hibernation && !unit_clk_en.hibernation
    |=> unit_fault.hibernation)
    else $error("hibernation access while gated gave no fault");

  // every unit at once: the outcome follows the enable in force
  a_unit_outcome: assert property (
    seen_clk |=> unit_grant == $past(unit_access & unit_clk_en)
                 && unit_fault == $past(unit_access & ~unit_clk_en))
    else $error("unit access outcome differs from its enable");

  c_reg_write: cover property (wr_done);
  c_reg_read: cover property (
    access_phase && pready && !pwrite && addr_hit);
  c_sleep_used: cover property (use_sleep ##1 use_sleep);
  c_bad_addr: cover property (pready && pslverr);

endmodule

/* File: rtl/sleep_gate_pkg.sv */
package sleep_gate_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register map, byte address within the system control window
  localparam logic [ADDR_W-1:0] SLEEP_CLOCK_GATE_0_OFS = 12'h0110;

  // ---------------------------------------------------------------
  // field layout of sleep_clock_gate_0
  // ---------------------------------------------------------------
  localparam int ADC_BIT         = 16;
  localparam int RATE_MSB        = 9;
  localparam int RATE_LSB        = 8;
  localparam int HIBERNATION_BIT = 6;
  localparam int WATCHDOG_BIT    = 3;

  // reset word and the bits software may change
  localparam logic [DATA_W-1:0] SLEEP_CLOCK_GATE_0_RST   = 32'h0000_0040;
  localparam logic [DATA_W-1:0] SLEEP_CLOCK_GATE_0_WMASK = 32'h0001_0348;

  localparam int N_UNITS = 3;

  // converter sample rate codes
  typedef enum logic [1:0] {
    RATE_125K = 2'h0,
    RATE_250K = 2'h1,
    RATE_500K = 2'h2,
    RATE_1M   = 2'h3
  } sample_rate_t;

  // one clock enable per gated unit
  typedef struct packed {
    logic adc;
    logic hibernation;
    logic watchdog;
  } unit_gate_t;

  // everything one gating register holds
  typedef struct packed {
    unit_gate_t   gate;
    sample_rate_t rate;
  } gate_cfg_t;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

  // register word to fields; reserved bits are simply dropped
  function automatic gate_cfg_t word_to_cfg(input logic [DATA_W-1:0] w);
    gate_cfg_t c;
    c.gate.adc         = w[ADC_BIT];
    c.gate.hibernation = w[HIBERNATION_BIT];
    c.gate.watchdog    = w[WATCHDOG_BIT];
    c.rate             = sample_rate_t'(w[RATE_MSB:RATE_LSB]);
    return c;
  endfunction

  // fields to register word; reserved bits read as zero
  function automatic logic [DATA_W-1:0] cfg_to_word(input gate_cfg_t c);
    logic [DATA_W-1:0] w;
    w                    = '0;
    w[ADC_BIT]           = c.gate.adc;
    w[HIBERNATION_BIT]   = c.gate.hibernation;
    w[WATCHDOG_BIT]      = c.gate.watchdog;
    w[RATE_MSB:RATE_LSB] = c.rate;
    return w;
  endfunction

  localparam gate_cfg_t CFG_RST = word_to_cfg(SLEEP_CLOCK_GATE_0_RST);

endpackage

/* File: rtl/unit_access_guard.sv */
`timescale 1ns/1ps

module unit_access_guard
  import sleep_gate_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // access attempt and the unit's current clock enable
  input  wire logic access,
  input  wire logic clk_en,
  // outcome, registered one cycle behind access, high for as long as access is held
  output logic      fault,
  output logic      grant
);

  // ---------------------------------------------------------------
  // access outcome
  // ---------------------------------------------------------------

  // a gated unit cannot answer, so the attempt turns into a fault
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
      grant <= 1'b0;
    end else begin
      fault <= access & ~clk_en;
      grant <= access & clk_en;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_gated_fault: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access && !clk_en |=> fault && !grant)
    else $error("access to gated unit gave no fault");

  a_open_grant: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    access && clk_en |=> grant && !fault)
    else $error("access to clocked unit was faulted");

  c_fault_seen: cover property (
    @(posedge core_clk) disable iff (!rst_n) fault);

endmodule

/* File: tb/sleep_clock_gating_tb.sv */
`timescale 1ns/1ps

module sleep_clock_gating_tb;
  import sleep_gate_pkg::*;

  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  localparam gate_cfg_t RUN_CFG  = 5'h15; // converter, watchdog, 250K
  localparam gate_cfg_t DEEP_CFG = 5'h0E; // hibernation, watchdog, 500K
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0040;

  logic              core_clk               = 1'b0;
  logic              rst_n                  = 1'b0;
  logic              psel                   = 1'b0;
  logic              penable                = 1'b0;
  logic              pwrite                 = 1'b0;
  logic [ADDR_W-1:0] paddr                  = '0;
  logic [DATA_W-1:0] pwdata                 = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              sleep_mode             = 1'b0;
  logic              deep_sleep_mode        = 1'b0;
  logic              auto_clock_gate_select = 1'b0;
  unit_gate_t        unit_access            = '0;
  unit_gate_t        unit_clk_en;
  unit_gate_t        unit_fault;
  unit_gate_t        unit_grant;
  sample_rate_t      converter_sample_rate;
  logic [DATA_W-1:0] rd;
  logic              err;
  int                mismatches             = 0;
  int                checks                 = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  sleep_clock_gating DUT (
    .core_clk                (core_clk),
    .rst_n                   (rst_n),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .sleep_mode              (sleep_mode),
    .deep_sleep_mode         (deep_sleep_mode),
    .auto_clock_gate_select  (auto_clock_gate_select),
    .run_clock_gate_0        (RUN_CFG),
    .deep_sleep_clock_gate_0 (DEEP_CFG),
    .unit_clk_en             (unit_clk_en),
    .converter_sample_rate   (converter_sample_rate),
    .unit_access             (unit_access),
    .unit_fault              (unit_fault),
    .unit_grant              (unit_grant)
  );

  // ---------------------------------------------------------------
  // verdict and comparisons
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [DATA_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_gate(input unit_gate_t got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t gates %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_rate(input sample_rate_t got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t rate %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // bus and port drivers
  // ---------------------------------------------------------------
  // request held until pready is sampled high; no latency assumed
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t bus never answered", $time);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic exp_err);
    apb(1'b1, a, d);
    cmp_flag(err, exp_err);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] exp, input logic exp_err);
    apb(1'b0, a, '0);
    cmp_word(rd, exp);
    cmp_flag(err, exp_err);
  endtask

  // select a power mode, then look at the settled enables and rate
  task automatic mode(input logic a, s, dp, input gate_cfg_t exp);
    @(posedge core_clk);
    auto_clock_gate_select <= a;
    sleep_mode             <= s;
    deep_sleep_mode        <= dp;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp_gate(unit_clk_en, exp.gate);
    cmp_rate(converter_sample_rate, exp.rate);
  endtask

  // one access cycle for the units in acc at once; gated units must fault, others complete
  task automatic touch(input unit_gate_t acc, input unit_gate_t en);
    @(posedge core_clk);
    unit_access <= acc;
    @(posedge core_clk);
    unit_access <= '0;
    @(negedge core_clk);
    cmp_gate(unit_fault, acc & ~en);
    cmp_gate(unit_grant, acc & en);
  endtask

  // own decode of a register word into its fields
  function automatic gate_cfg_t cfg_of(input logic [DATA_W-1:0] w);
    return gate_cfg_t'({w[16], w[6], w[3], w[9:8]});
  endfunction

  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    $display("ERROR %0t run timed out", $time);
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [DATA_W-1:0] words [4];
    gate_cfg_t         c;
    words = '{32'h0001_0008, 32'h0000_0148, 32'h0001_0240, 32'h0000_0300};
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    cmp_gate(unit_clk_en, 3'b010);
    cmp_flag(pready, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(SLEEP_CLOCK_GATE_0_OFS, RST_WORD, 1'b0);
    rdc(12'h100, 32'h0000_0000, 1'b1);
    wr(12'h114, 32'hFFFF_FFFF, 1'b1);
    rdc(SLEEP_CLOCK_GATE_0_OFS, RST_WORD, 1'b0);
    wr(SLEEP_CLOCK_GATE_0_OFS, 32'hFFFF_FFFF, 1'b0);
    rdc(SLEEP_CLOCK_GATE_0_OFS, 32'h0001_0348, 1'b0);
    wr(SLEEP_CLOCK_GATE_0_OFS, 32'h0000_0000, 1'b0);
    rdc(SLEEP_CLOCK_GATE_0_OFS, 32'h0000_0000, 1'b0);
    mode(1'b1, 1'b1, 1'b0, cfg_of(32'h0));
    touch(3'b111, 3'b000);
    // every rate code with a different gate pattern each time
    for (int i = 0; i < 4; i++) begin
      wr(SLEEP_CLOCK_GATE_0_OFS, words[i], 1'b0);
      rdc(SLEEP_CLOCK_GATE_0_OFS, words[i], 1'b0);
      c = cfg_of(words[i]);
      mode(1'b1, 1'b1, 1'b0, c);
      touch(3'b111, c.gate);
    end
    mode(1'b0, 1'b1, 1'b0, RUN_CFG);
    touch(3'b111, RUN_CFG.gate);
    mode(1'b1, 1'b0, 1'b0, RUN_CFG);
    mode(1'b1, 1'b1, 1'b1, DEEP_CFG);
    touch(3'b101, DEEP_CFG.gate);
    mode(1'b1, 1'b1, 1'b0, c);
    // second reset in mid-run restores the reset word
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(SLEEP_CLOCK_GATE_0_OFS, RST_WORD, 1'b0);
    mode(1'b1, 1'b1, 1'b0, cfg_of(RST_WORD));
    report_and_stop();
  end

endmodule
